// ### design/hpi_pkg.sv
// Purpose: Shared constants and types for the host phy init block
// Assumes: System clock of 100 MHz, first-generation dword timing
// Notes:   Line times are kept in picoseconds so fractions stay exact; align timeout is in us, poll in ns
package hpi_pkg;

   // System clock period
   localparam int unsigned CLK_PS          = 10000;

   // Line timing, printed figures in picoseconds, align timeout in us, poll in ns
   localparam int unsigned D10_START_PS    = 533000;
   localparam int unsigned WAKE_IDLE_PS    = 175000;
   localparam int unsigned DEV_START_PS    = 53300;
   localparam int unsigned EARLY_DET_PS    = 112000;
   localparam int unsigned ALIGN_TMO_US    = 880;
   localparam int unsigned POLL_NS         = 10000;

   // Longest time rounds down
   localparam int unsigned D10_START_CYC   = D10_START_PS / CLK_PS;
   // Least times round up
   localparam int unsigned GUARD_PS        =
      WAKE_IDLE_PS + DEV_START_PS - EARLY_DET_PS;
   localparam int unsigned GUARD_CYC       =
      (GUARD_PS + CLK_PS - 1) / CLK_PS;
   localparam int unsigned ALIGN_TMO_CYC   =
      (ALIGN_TMO_US * 1000000 + CLK_PS - 1) / CLK_PS;
   localparam int unsigned POLL_CYC        =
      (POLL_NS * 1000 + CLK_PS - 1) / CLK_PS;

   localparam int unsigned TMR_W           = 17;
   localparam int unsigned NONALIGN_RUN    = 3;

   // Dword encodings, byte 0 in the low bits
   localparam logic [31:0] ALIGN_WORD      = 32'h7B4A4ABC;
   localparam logic [3:0]  ALIGN_ISK       = 4'h1;
   localparam logic [31:0] D10_2_WORD      = 32'h4A4A4A4A;
   localparam logic [7:0]  K28_3_BYTE      = 8'h7C;
   localparam logic [31:0] IDLE_WORD       = 32'h00000000;
   localparam logic [3:0]  NO_ISK          = 4'h0;

   // Transmit content, adjacent codes differ in one bit along the flow
   typedef enum logic [1:0] {
      HPI_TX_QUIET = 2'h0,
      HPI_TX_D10   = 2'h1,
      HPI_TX_ALIGN = 2'h3,
      HPI_TX_LINK  = 2'h2
   } hpi_tx_e;

   typedef enum logic [2:0] {
      host_init_restart_state,
      host_wake_send_state,
      host_wake_end_wait_state,
      host_wait_sync_primitive,
      host_transmit_sync_primitive,
      host_link_up_state,
      host_light_sleep_state,
      host_deep_sleep_state
   } hpi_state_e;

endpackage : hpi_pkg

// ### design/hpi_link_if.sv
// Purpose: Carrier between the control domain and the link-clock side
// Assumes: Each side synchronises what it receives
// Notes:   Only levels cross here
interface hpi_link_if;
   hpi_pkg::hpi_tx_e tx_mode;
   logic             search_en;
   logic             rx_align;
   logic             rx_nonalign3;

   modport ctl (output tx_mode, output search_en,
                input rx_align, input rx_nonalign3);
   modport lnk (input tx_mode, input search_en,
                output rx_align, output rx_nonalign3);
endinterface : hpi_link_if

// ### design/hpi_sync.sv
// Purpose: Two-stage level synchroniser, one chain per bit
// Assumes: Inputs are levels held far longer than two clocks
// Notes:   First stage is read by the second stage only
module hpi_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         logic meta_r;
         logic hold_r;
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= d[gi];
               hold_r <= meta_r;
            end
         end
         assign q[gi] = hold_r;
      end
   endgenerate
endmodule : hpi_sync

// ### design/hpi_link_side.sv
// Purpose: Link-clock receive detectors and transmit word selection
// Assumes: The phy clock runs free while the block is out of reset
// Notes:   Detector flags are sticky until the search enable drops
module hpi_link_side (
   input  wire logic        lclk,
   input  wire logic        arst_n,
   hpi_link_if.lnk          lnk,
   input  wire logic [31:0] rx_data,
   input  wire logic [3:0]  rx_isk,
   input  wire logic [31:0] tx_word,
   input  wire logic [3:0]  tx_word_isk,
   output logic      [31:0] tx_data,
   output logic      [3:0]  tx_isk,
   output logic             tx_idle
);
   logic        lrst_q_r;
   logic        lrst_n_r;
   logic [2:0]  ctl_s;
   logic        search_s;
   logic [1:0]  mode_s;
   logic        is_align;
   logic        is_nonalign;
   logic        count_on;
   logic [1:0]  run_r;
   logic [1:0]  run_nxt;
   logic        align_r;
   logic        nonalign3_r;
   logic [31:0] word_nxt;
   logic [3:0]  isk_nxt;

   always_ff @(posedge lclk or negedge arst_n) begin
      if (!arst_n) begin
         lrst_q_r <= 1'b0;
         lrst_n_r <= 1'b0;
      end else begin
         lrst_q_r <= 1'b1;
         lrst_n_r <= lrst_q_r;
      end
   end

   hpi_sync #(.W(3)) u_sync (
      .clk   (lclk),
      .rst_n (lrst_n_r),
      .d     ({lnk.search_en, lnk.tx_mode}),
      .q     (ctl_s)
   );
   assign search_s = ctl_s[2];
   assign mode_s   = ctl_s[1:0];

   assign is_align    = (rx_data == hpi_pkg::ALIGN_WORD) &&
                        (rx_isk == hpi_pkg::ALIGN_ISK);
   // Only byte 0 is checked for the marker
   assign is_nonalign = rx_isk[0] &&
                        (rx_data[7:0] == hpi_pkg::K28_3_BYTE);
   assign count_on    = search_s && (mode_s == hpi_pkg::HPI_TX_ALIGN);
   assign run_nxt     = (count_on && is_nonalign) ?
                        ((run_r == 2'h3) ? run_r : run_r + 2'h1) : 2'h0;

   always_ff @(posedge lclk or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         run_r       <= 2'h0;
         align_r     <= 1'b0;
         nonalign3_r <= 1'b0;
      end else begin
         run_r       <= run_nxt;
         align_r     <= search_s && (align_r || is_align);
         nonalign3_r <= count_on && (nonalign3_r ||
                        (32'(run_nxt) >= hpi_pkg::NONALIGN_RUN));
      end
   end
   assign lnk.rx_align     = align_r;
   assign lnk.rx_nonalign3 = nonalign3_r;

   always_comb begin
      word_nxt = hpi_pkg::IDLE_WORD;
      isk_nxt  = hpi_pkg::NO_ISK;
      case (mode_s)
         hpi_pkg::HPI_TX_D10: begin
            word_nxt = hpi_pkg::D10_2_WORD;
         end
         hpi_pkg::HPI_TX_ALIGN: begin
            word_nxt = hpi_pkg::ALIGN_WORD;
            isk_nxt  = hpi_pkg::ALIGN_ISK;
         end
         hpi_pkg::HPI_TX_LINK: begin
            word_nxt = tx_word;
            isk_nxt  = tx_word_isk;
         end
         default: begin
            word_nxt = hpi_pkg::IDLE_WORD;
            isk_nxt  = hpi_pkg::NO_ISK;
         end
      endcase
   end

   always_ff @(posedge lclk or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         tx_data <= hpi_pkg::IDLE_WORD;
         tx_isk  <= hpi_pkg::NO_ISK;
         tx_idle <= 1'b1;
      end else begin
         tx_data <= word_nxt;
         tx_isk  <= isk_nxt;
         tx_idle <= (mode_s == hpi_pkg::HPI_TX_QUIET);
      end
   end
endmodule : hpi_link_side

// ### design/hpi_top.sv
// Purpose: Host phy init machine, alignment through power states
// Assumes: Out-of-band detector and lock pins are asynchronous levels
// Notes:   Speed adjust and the early reset states live elsewhere
//
// Functional notes
// - After an init failure, restart repeatedly unless retries are disabled.
// - Start D10.2 within 533ns after device wake ends.
// - Delay the ALIGN search after wake end to dodge idle crosstalk.
// - The restart state may serve for speed negotiation.
// - Send ALIGN; three back-to-back non-ALIGN primitives move to ready.
// - Retry in send-align without limit unless retries are disabled.
// - Non-ALIGN means K28.3 in byte 0.
// - Ready transmits link words and clears resume pending if enabled.
// - Slumber request in ready, without a partial request, enters deep sleep.
// - Stay ready with no request and no recovery poll active.
// - No signal with recovery poll enabled sends ready to restart.
// - Link-up flag only in ready, with rx lock and valid tx.
// - Light sleep is quiet and sets resume pending if enabled.
// - Partial drop goes to wake send, or wake-end wait if woken.
// - Remember whether the device sent wake during sleep.
// - Deep sleep is quiet and sets resume pending if enabled.
// - Slumber drop exits likewise, but only after recovering.
// - No ALIGN within 880us of align-wait entry returns to restart.
module hpi_top #(
   parameter int unsigned ALIGN_TMO_CYC = hpi_pkg::ALIGN_TMO_CYC
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        lclk,
   input  wire logic        comwake_det,
   input  wire logic        signal_det,
   input  wire logic        rx_locked,
   input  wire logic        tx_good,
   input  wire logic        sleep_recovered,
   input  wire logic        partial_req,
   input  wire logic        slumber_req,
   input  wire logic        retry_dis,
   input  wire logic        async_rec_en,
   input  wire logic [31:0] rx_data,
   input  wire logic [3:0]  rx_isk,
   input  wire logic [31:0] tx_word,
   input  wire logic [3:0]  tx_word_isk,
   output logic      [31:0] tx_data,
   output logic      [3:0]  tx_isk,
   output logic             tx_idle,
   output logic             comwake_tx,
   output logic             init_restart,
   output logic             phy_link_up_flag,
   output logic             resume_pending_flag,
   output logic             wake_from_dev,
   output logic      [2:0]  state_code
);
   localparam logic [hpi_pkg::TMR_W-1:0] GUARD_C =
      hpi_pkg::TMR_W'(hpi_pkg::GUARD_CYC);
   localparam logic [hpi_pkg::TMR_W-1:0] POLL_C =
      hpi_pkg::TMR_W'(hpi_pkg::POLL_CYC);
   localparam logic [hpi_pkg::TMR_W-1:0] TMO_C =
      hpi_pkg::TMR_W'(ALIGN_TMO_CYC - 1);

   hpi_link_if link_if ();

   logic                     rst_q_r;
   logic                     rst_n_r;
   logic [6:0]               pin_s;
   logic [1:0]               det_s;
   logic                     wake_s;
   logic                     sig_s;
   logic                     lock_s;
   logic                     txok_s;
   logic                     recov_s;
   logic                     align_s;
   logic                     nonalign3_s;
   hpi_pkg::hpi_state_e      state_r;
   hpi_pkg::hpi_state_e      state_nxt;
   logic [hpi_pkg::TMR_W-1:0] tmr_r;
   logic [hpi_pkg::TMR_W-1:0] poll_r;
   logic                     state_chg;
   logic                     guard_done;
   logic                     align_tmo;
   logic                     poll_due;
   logic                     in_sleep;
   logic                     resume_nxt;
   logic                     wake_seen_nxt;
   logic                     link_up_nxt;
   hpi_pkg::hpi_tx_e         tx_mode_nxt;

   // Reset release through two flops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_q_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_q_r <= 1'b1;
         rst_n_r <= rst_q_r;
      end
   end

   hpi_sync #(.W(7)) u_pin_sync (
      .clk   (clk),
      .rst_n (rst_n_r),
      .d     ({link_if.rx_nonalign3, link_if.rx_align, sleep_recovered,
               tx_good, rx_locked, signal_det, comwake_det}),
      .q     (pin_s)
   );
   assign wake_s      = pin_s[0];
   assign sig_s       = pin_s[1];
   assign lock_s      = pin_s[2];
   assign txok_s      = pin_s[3];
   assign recov_s     = pin_s[4];
   assign det_s       = pin_s[6:5];
   assign align_s     = det_s[0];
   assign nonalign3_s = det_s[1];

   hpi_link_side u_link (
      .lclk        (lclk),
      .arst_n      (arst_n),
      .lnk         (link_if.lnk),
      .rx_data     (rx_data),
      .rx_isk      (rx_isk),
      .tx_word     (tx_word),
      .tx_word_isk (tx_word_isk),
      .tx_data     (tx_data),
      .tx_isk      (tx_isk),
      .tx_idle     (tx_idle)
   );

   assign state_chg  = (state_nxt != state_r);
   // Crosstalk on the idle line must not pass for ALIGN
   assign guard_done = (tmr_r >= GUARD_C);
   assign align_tmo  = (tmr_r >= TMO_C);
   // Poll interval sits well above the ALIGN spacing
   assign poll_due   = (poll_r >= POLL_C);
   assign in_sleep   = (state_r == hpi_pkg::host_light_sleep_state) ||
                       (state_r == hpi_pkg::host_deep_sleep_state);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hpi_pkg::host_init_restart_state: begin
            // Parked here once software turns retries off
            if (!retry_dis) begin
               state_nxt = hpi_pkg::host_wake_send_state;
            end
         end
         hpi_pkg::host_wake_send_state: begin
            if (wake_s) begin
               state_nxt = hpi_pkg::host_wake_end_wait_state;
            end
         end
         hpi_pkg::host_wake_end_wait_state: begin
            if (!wake_s) begin
               state_nxt = hpi_pkg::host_wait_sync_primitive;
            end
         end
         hpi_pkg::host_wait_sync_primitive: begin
            if (guard_done && align_s) begin
               state_nxt = hpi_pkg::host_transmit_sync_primitive;
            end else if (align_tmo) begin
               state_nxt = hpi_pkg::host_init_restart_state;
            end
         end
         hpi_pkg::host_transmit_sync_primitive: begin
            if (nonalign3_s) begin
               state_nxt = hpi_pkg::host_link_up_state;
            end else if (retry_dis && align_tmo) begin
               // Without retries, give up after one timeout span
               state_nxt = hpi_pkg::host_init_restart_state;
            end
         end
         hpi_pkg::host_link_up_state: begin
            if (partial_req) begin
               state_nxt = hpi_pkg::host_light_sleep_state;
            end else if (slumber_req) begin
               state_nxt = hpi_pkg::host_deep_sleep_state;
            end else if (async_rec_en && !sig_s && poll_due) begin
               state_nxt = hpi_pkg::host_init_restart_state;
            end // Otherwise stay
         end
         hpi_pkg::host_light_sleep_state: begin
            if (!partial_req) begin
               state_nxt = wake_from_dev ?
                  hpi_pkg::host_wake_end_wait_state :
                  hpi_pkg::host_wake_send_state;
            end
         end
         hpi_pkg::host_deep_sleep_state: begin
            if (!slumber_req && recov_s) begin
               state_nxt = wake_from_dev ?
                  hpi_pkg::host_wake_end_wait_state :
                  hpi_pkg::host_wake_send_state;
            end
         end
         default: begin
            state_nxt = hpi_pkg::host_init_restart_state;
         end
      endcase
   end

   always_comb begin
      tx_mode_nxt = hpi_pkg::HPI_TX_QUIET;
      case (state_nxt)
         hpi_pkg::host_wait_sync_primitive: begin
            tx_mode_nxt = hpi_pkg::HPI_TX_D10;
         end
         hpi_pkg::host_transmit_sync_primitive: begin
            tx_mode_nxt = hpi_pkg::HPI_TX_ALIGN;
         end
         hpi_pkg::host_link_up_state: begin
            tx_mode_nxt = hpi_pkg::HPI_TX_LINK;
         end
         default: begin
            tx_mode_nxt = hpi_pkg::HPI_TX_QUIET;
         end
      endcase
   end

   assign resume_nxt =
      (async_rec_en && in_sleep) ? 1'b1 :
      (async_rec_en && (state_r == hpi_pkg::host_link_up_state)) ?
      1'b0 : resume_pending_flag;
   // Cleared while in ready; any wake seen in sleep is kept
   assign wake_seen_nxt =
      (state_r == hpi_pkg::host_link_up_state) ? 1'b0 :
      (in_sleep && wake_s) ? 1'b1 : wake_from_dev;
   assign link_up_nxt = (state_r == hpi_pkg::host_link_up_state) &&
                        (state_nxt == hpi_pkg::host_link_up_state) &&
                        lock_s && txok_s;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= hpi_pkg::host_init_restart_state;
         tmr_r   <= '0;
      end else begin
         state_r <= state_nxt;
         tmr_r   <= (state_chg || align_tmo) ? '0 : tmr_r + 1'b1;
      end
   end

   // Poll timer runs only while ready and the line is silent
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         poll_r <= '0;
      end else if ((state_r != hpi_pkg::host_link_up_state) || sig_s) begin
         poll_r <= '0;
      end else if (!poll_due) begin
         poll_r <= poll_r + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         link_if.tx_mode     <= hpi_pkg::HPI_TX_QUIET;
         link_if.search_en   <= 1'b0;
         resume_pending_flag <= 1'b0;
         wake_from_dev       <= 1'b0;
         phy_link_up_flag    <= 1'b0;
         comwake_tx          <= 1'b0;
         init_restart        <= 1'b1;
      end else begin
         link_if.tx_mode     <= tx_mode_nxt;
         link_if.search_en   <=
            ((state_nxt == hpi_pkg::host_wait_sync_primitive) &&
             !state_chg && guard_done) ||
            (state_nxt == hpi_pkg::host_transmit_sync_primitive);
         resume_pending_flag <= resume_nxt;
         wake_from_dev       <= wake_seen_nxt;
         phy_link_up_flag    <= link_up_nxt;
         comwake_tx <= (state_nxt == hpi_pkg::host_wake_send_state);
         init_restart <= (state_nxt == hpi_pkg::host_init_restart_state);
      end
   end

   assign state_code = 3'(state_r);
endmodule : hpi_top

// ### verif/hpi_properties.sv
// Purpose: Port-level properties of the host phy init block
// Assumes: All watched ports sit in the system clock domain
// Notes:   Bound into every hpi_top instance
module hpi_properties #(
   parameter int unsigned ALIGN_TMO_CYC = 200
) (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       partial_req,
   input wire logic       slumber_req,
   input wire logic       retry_dis,
   input wire logic       async_rec_en,
   input wire logic       init_restart,
   input wire logic       phy_link_up_flag,
   input wire logic       resume_pending_flag,
   input wire logic [2:0] state_code
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   logic [17:0] sync_wait_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) sync_wait_r <= '0;
      else if (state_code == 3'h3) sync_wait_r <= sync_wait_r + 18'h1;
      else sync_wait_r <= '0;
   end

   // Flag drops at the same edge as the state leaves ready
   property p_up_ready;
      phy_link_up_flag |-> state_code == 3'h5;
   endproperty
   a_up_ready: assert property (p_up_ready) else $error("up flag");
   property p_part_in;
      state_code == 3'h5 && partial_req |=> state_code == 3'h6;
   endproperty
   a_part_in: assert property (p_part_in) else $error("partial");
   property p_slum_in;
      state_code == 3'h5 && slumber_req && !partial_req |=> state_code == 3'h7;
   endproperty
   a_slum_in: assert property (p_slum_in) else $error("slumber");
   property p_part_stay;
      state_code == 3'h6 && partial_req |=> state_code == 3'h6;
   endproperty
   a_part_stay: assert property (p_part_stay) else $error("stay");
   property p_part_out;
      state_code == 3'h6 && !partial_req |=> state_code inside {3'h1, 3'h2};
   endproperty
   a_part_out: assert property (p_part_out) else $error("exit");
   property p_park;
      state_code == 3'h0 && retry_dis |=> state_code == 3'h0;
   endproperty
   a_park: assert property (p_park) else $error("park");
   property p_rp_set;
      state_code inside {3'h6, 3'h7} && async_rec_en |=> resume_pending_flag;
   endproperty
   a_rp_set: assert property (p_rp_set) else $error("rp set");
   property p_rp_clr;
      state_code == 3'h5 && async_rec_en |=> !resume_pending_flag;
   endproperty
   a_rp_clr: assert property (p_rp_clr) else $error("rp clear");
   property p_restart;
      init_restart == (state_code == 3'h0);
   endproperty
   a_restart: assert property (p_restart) else $error("restart");
   property p_tmo;
      sync_wait_r <= ALIGN_TMO_CYC + 2;
   endproperty
   a_tmo: assert property (p_tmo) else $error("align wait");
endmodule : hpi_properties

bind hpi_top hpi_properties #(.ALIGN_TMO_CYC(ALIGN_TMO_CYC)) u_prop (
   .clk(clk), .arst_n(arst_n), .partial_req(partial_req),
   .slumber_req(slumber_req), .retry_dis(retry_dis),
   .async_rec_en(async_rec_en), .init_restart(init_restart),
   .phy_link_up_flag(phy_link_up_flag),
   .resume_pending_flag(resume_pending_flag), .state_code(state_code));

// ### verif/hpi_dev_model.sv
// Purpose: Attached device phy, receive words seen by the host
// Assumes: One queued word leaves per link clock
// Notes:   Queue wins over the default word
module hpi_dev_model (
   input  wire logic        lclk,
   input  wire logic        dflt_on,
   input  wire logic [35:0] dflt_w,
   output logic      [31:0] rx_data,
   output logic      [3:0]  rx_isk
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [35:0] q[$];
   logic [35:0] w;
   task automatic push(input logic [35:0] v);
      q.push_back(v);
   endtask : push
   initial begin
      rx_data = 32'h00000000;
      rx_isk = 4'h0;
   end
   always @(posedge lclk) begin
      if (q.size() != 0) w = q.pop_front();
      else if (dflt_on) w = dflt_w;
      // Idle line: flipping pattern so no stale word is mistaken
      else w = {4'h0, ~rx_data};
      rx_data <= w[31:0];
      rx_isk <= w[35:32];
   end
endmodule : hpi_dev_model

// ### verif/tb.sv
// Purpose: Self-checking bench for the host phy init block
// Assumes: Short align timeout, link clock of 64 ns
// Notes:   Device words come from hpi_dev_model
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned TMO = 200;
   localparam logic [35:0] ALN = {hpi_pkg::ALIGN_ISK, hpi_pkg::ALIGN_WORD};
   logic        clk, lclk, arst_n, comwake_det, signal_det, rx_locked;
   logic        tx_good, sleep_recovered, partial_req, slumber_req;
   logic        retry_dis, async_rec_en, tx_idle, comwake_tx, init_restart;
   logic        phy_link_up_flag, resume_pending_flag, wake_from_dev;
   logic        dflt_on;
   logic [31:0] tx_word, rx_data, tx_data;
   logic [3:0]  tx_word_isk, rx_isk, tx_isk;
   logic [2:0]  state_code;
   logic [35:0] dflt_w;
   int          failures, n_checks, seed, cycles;
   time         t0;

   hpi_top #(.ALIGN_TMO_CYC(TMO)) uut (
      .clk(clk), .arst_n(arst_n), .lclk(lclk), .comwake_det(comwake_det),
      .signal_det(signal_det), .rx_locked(rx_locked), .tx_good(tx_good),
      .sleep_recovered(sleep_recovered), .partial_req(partial_req),
      .slumber_req(slumber_req), .retry_dis(retry_dis),
      .async_rec_en(async_rec_en), .rx_data(rx_data), .rx_isk(rx_isk),
      .tx_word(tx_word), .tx_word_isk(tx_word_isk), .tx_data(tx_data),
      .tx_isk(tx_isk), .tx_idle(tx_idle), .comwake_tx(comwake_tx),
      .init_restart(init_restart), .phy_link_up_flag(phy_link_up_flag),
      .resume_pending_flag(resume_pending_flag),
      .wake_from_dev(wake_from_dev), .state_code(state_code));
   hpi_dev_model dev (.lclk(lclk), .dflt_on(dflt_on), .dflt_w(dflt_w),
      .rx_data(rx_data), .rx_isk(rx_isk));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Odd offset keeps the two clocks unrelated
   initial begin
      lclk = 1'b0;
      #7;
      forever #32 lclk = ~lclk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk_v(input logic [35:0] got, input logic [35:0] exp,
                        input string m);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         failures = failures + 1;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_v

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic wait_st(input logic [2:0] s, input int n);
      int i;
      i = 0;
      while (state_code !== s && i < n) begin
         tick(1);
         i++;
      end
      chk_v(state_code, s, "state");
   endtask : wait_st

   function automatic logic [35:0] na();
      logic [31:0] r;
      r = $random(seed);
      return {4'h1, r[31:8], hpi_pkg::K28_3_BYTE};
   endfunction : na

   // Device answers the host wake, then goes idle
   task automatic to_sync();
      int i;
      wait_st(3'h1, 40);
      chk_v(comwake_tx, 1'b1, "wake tx");
      @(posedge clk) comwake_det <= 1'b1;
      wait_st(3'h2, 20);
      @(posedge clk) comwake_det <= 1'b0;
      t0 = $time;
      // Early ALIGN lands inside the guard gap and must be ignored
      dev.push(ALN);
      i = 0;
      while (tx_data !== hpi_pkg::D10_2_WORD && i < 100) begin
         tick(1);
         i++;
      end
      chk_v(($time - t0) <= 533, 1'b1, "d10 late");
   endtask : to_sync

   task automatic bring_up();
      logic [31:0] r;
      r = $random(seed);
      @(posedge clk) dflt_on <= 1'b1;
      wait_st(3'h4, 80);
      tick(30);
      chk_v({tx_isk, tx_data}, ALN, "align tx");
      // Broken runs: ALIGN and K28.3 off byte 0 both restart the count
      for (int k = 0; k < 6; k++)
         dev.push(k == 2 ? ALN :
                  k == 3 ? {4'h2, r[31:16], hpi_pkg::K28_3_BYTE, 8'hBC} :
                  na());
      tick(80);
      chk_v(state_code, 3'h4, "short run");
      repeat (3) dev.push(na());
      wait_st(3'h5, 80);
   endtask : bring_up

   initial begin
      seed = 44;
      {failures, n_checks, cycles} = '0;
      {arst_n, comwake_det, sleep_recovered, partial_req, slumber_req} = '0;
      {async_rec_en, dflt_on, tx_word, tx_word_isk} = '0;
      {signal_det, rx_locked, tx_good, retry_dis} = 4'hF;
      dflt_w = ALN;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      tick(40);
      chk_v(init_restart, 1'b1, "parked");
      @(posedge clk) retry_dis <= 1'b0;
      to_sync();
      // Early ALIGN from to_sync, then silence
      tick(TMO - 40);
      chk_v(state_code, 3'h3, "early align");
      wait_st(3'h0, 80);
      to_sync();
      bring_up();
      for (int k = 0; k < 3; k++) begin
         @(posedge clk) {tx_word_isk, tx_word} <= 36'($random(seed));
         tick(40);
         chk_v({tx_isk, tx_data}, {tx_word_isk, tx_word}, "link tx");
      end
      chk_v(phy_link_up_flag, 1'b1, "up");
      @(posedge clk) rx_locked <= 1'b0;
      tick(6);
      chk_v(phy_link_up_flag, 1'b0, "no lock");
      @(posedge clk) rx_locked <= 1'b1;
      @(posedge clk) async_rec_en <= 1'b1;
      tick(1100);
      chk_v(state_code, 3'h5, "ready");
      chk_v(resume_pending_flag, 1'b0, "rp");
      @(posedge clk) partial_req <= 1'b1;
      tick(40);
      chk_v({state_code, tx_idle}, {3'h6, 1'b1}, "quiet");
      chk_v(resume_pending_flag, 1'b1, "rp");
      @(posedge clk) comwake_det <= 1'b1;
      tick(6);
      @(posedge clk) partial_req <= 1'b0;
      wait_st(3'h2, 10);
      chk_v(wake_from_dev, 1'b1, "woken");
      @(posedge clk) comwake_det <= 1'b0;
      bring_up();
      // Wake flag clears one edge after link-up is entered
      tick(2);
      chk_v(wake_from_dev, 1'b0, "woken");
      @(posedge clk) slumber_req <= 1'b1;
      tick(40);
      chk_v({state_code, tx_idle}, {3'h7, 1'b1}, "quiet");
      @(posedge clk) slumber_req <= 1'b0;
      tick(30);
      chk_v(state_code, 3'h7, "unrecovered");
      chk_v(resume_pending_flag, 1'b1, "rp");
      @(posedge clk) sleep_recovered <= 1'b1;
      to_sync();
      bring_up();
      @(posedge clk) signal_det <= 1'b0;
      tick(900);
      chk_v(state_code, 3'h5, "poll early");
      wait_st(3'h0, 200);
      tally_and_finish();
   end
endmodule : tb
